// ---- hw/tmos_pkg.sv ----
// Package: constants, register map and carrier types of the thermal overload stage
package tmos_pkg;
  // Clock rate and millisecond time base for event stamps
  localparam int unsigned CLK_FREQ_HZ    = 200_000_000;
  localparam int unsigned STAMP_RES_US   = 1000;
  localparam int unsigned CYCLES_PER_MS  = CLK_FREQ_HZ / 1_000_000 * STAMP_RES_US;
  localparam int unsigned MEAS_PERIOD_MS = 5;
  // Stage structure
  localparam int unsigned NUM_SETS       = 8;
  localparam int unsigned NUM_OUTS       = 5;
  localparam int unsigned CNT_WIDTH      = 16;
  localparam int unsigned AMB_SHIFT      = 4;
  // Register byte offsets
  localparam logic [7:0] REG_CTRL        = 8'h00;
  localparam logic [7:0] REG_GROUP       = 8'h04;
  localparam logic [7:0] REG_STATE       = 8'h08;
  localparam logic [7:0] REG_THETA       = 8'h0c;
  localparam logic [7:0] REG_IRQ_STAT    = 8'h10;
  localparam logic [7:0] REG_IRQ_MASK    = 8'h14;
  localparam logic [7:0] REG_CNT_CLR     = 8'h18;
  localparam logic [7:0] REG_SET_INDEX   = 8'h1c;
  localparam logic [7:0] REG_SET_LEVELS  = 8'h20;
  localparam logic [7:0] REG_SET_TIMING  = 8'h24;
  localparam logic [7:0] REG_CNT_BASE    = 8'h40;
  // Control field positions and reset values
  localparam int unsigned CTRL_EN_BIT    = 0;
  localparam int unsigned CTRL_FEN_BIT   = 1;
  localparam int unsigned CTRL_FCODE_LSB = 4;
  localparam logic [31:0] CTRL_RESET     = 32'h0000_0000;
  localparam logic [2:0]  GROUP_RESET    = 3'h0;
  // Output bit positions, also counter and event ids
  localparam int unsigned OUT_TRIP       = 0;
  localparam int unsigned OUT_ALARM1     = 1;
  localparam int unsigned OUT_ALARM2     = 2;
  localparam int unsigned OUT_INHIBIT    = 3;
  localparam int unsigned OUT_BLOCKED    = 4;

  // Forced status codes
  typedef enum logic [2:0] {
    FORCE_NORMAL  = 3'b000,
    FORCE_BLOCKED = 3'b001,
    FORCE_ALARM1  = 3'b010,
    FORCE_ALARM2  = 3'b011,
    FORCE_INHIBIT = 3'b100,
    FORCE_TRIP    = 3'b101
  } tmos_force_type;

  // One 5 ms measurement sample
  typedef struct packed {
    logic [15:0] phase_a_rms_current;
    logic [15:0] phase_b_rms_current;
    logic [15:0] phase_c_rms_current;
    logic [15:0] pos_seq_current;
    logic [15:0] neg_seq_current;
    logic [15:0] ambient_temp;
  } tmos_meas_type;

  // One parameter set
  typedef struct packed {
    logic [7:0] trip_lvl;
    logic [7:0] alarm1_lvl;
    logic [7:0] alarm2_lvl;
    logic [7:0] inhibit_lvl;
    logic [7:0] stall_lvl;
    logic [3:0] heat_shift;
    logic [3:0] cool_shift;
    logic [3:0] short_shift;
  } tmos_set_type;

  // Time-stamped ON/OFF event
  typedef struct packed {
    logic [2:0]  signal_id;
    logic        is_on;
    logic [31:0] stamp_ms;
  } tmos_event_type;
endpackage : tmos_pkg

// ---- hw/tmos_set_mem.sv ----
// Memory of the parameter sets with registered read data
module tmos_set_mem #(
  parameter int unsigned DEPTH = 8,
  parameter int unsigned WIDTH = 60
) (
  input  wire logic                     i_clk,
  input  wire logic                     i_wr_en,
  input  wire logic [$clog2(DEPTH)-1:0] i_wr_addr,
  input  wire logic [WIDTH-1:0]         i_wr_data,
  input  wire logic [$clog2(DEPTH)-1:0] i_rd_addr,
  output logic      [WIDTH-1:0]         o_rd_data
);
  logic [WIDTH-1:0] mem_reg [DEPTH];

  // Write port and registered read port
  always_ff @(posedge i_clk) begin
    if (i_wr_en) begin
      mem_reg[i_wr_addr] <= i_wr_data;
    end
    o_rd_data <= mem_reg[i_rd_addr];
  end
endmodule : tmos_set_mem

// ---- hw/tmos_stage.sv ----
// Thermal overload stage: replica pipeline, outputs, events, counters, Wishbone registers
// How it works
// R1 - Eight parameter sets held; one group register chooses the active set.
// R2 - Block input and group may change at run time; applied without restart.
// R3 - Five ordered stages: magnitude, replica, comparator, block check, output.
// R4 - Every output edge pushes an ON or OFF event stamped in milliseconds.
// R5 - Separate cumulative counters for trip, alarm1, alarm2, inhibit, blocked; clearable.
// R6 - Phase magnitudes are true RMS values over 32 harmonic components.
// R7 - Source delivers three phase RMS values every 5 ms; stage consumes them.
// R8 - Source delivers positive and negative sequence currents every 5 ms.
// R9 - Ambient temperature arrives every 5 ms and corrects the replica.
// R10 - Stage picks heating, stall or cooling time constant from settings and load.
// R11 - Cooling constant may be set two to three times the heating constant.
// R12 - Enable setting turns stage on or off; disabled after reset.
// R13 - With forcing enabled, force code overrides state; default normal.
// R14 - Outputs are levels; all but blocked held low while blocked.
// R15 - Counters saturate at maximum; cleared by reset or clear request.
//
// The placing of the registers and the Wishbone interface to the registers are this design's own decisions.
module tmos_stage
  import tmos_pkg::*;
#(
  parameter int unsigned MS_CYCLES = CYCLES_PER_MS
) (
  input  wire logic           I_SYS_CLK,
  input  wire logic           I_SYS_RST,
  input  wire logic           I_WB_CYC,
  input  wire logic           I_WB_STB,
  input  wire logic           I_WB_WE,
  input  wire logic [7:0]     I_WB_ADR,
  input  wire logic [31:0]    I_WB_DAT,
  input  wire logic [3:0]     I_WB_SEL,
  output logic      [31:0]    O_WB_DAT,
  output logic                O_WB_ACK,
  input  wire logic           I_MEAS_VALID,
  input  wire tmos_meas_type  I_MEAS,
  input  wire logic           I_BLOCK,
  output logic      [4:0]     O_STATE,
  output logic                O_EVT_VALID,
  output tmos_event_type      O_EVT,
  output logic                O_IRQ
);
  // Byte-lane merge of a Wishbone write into a register
  function automatic logic [31:0] wb_merge(input logic [31:0] old_v, input logic [31:0] new_v,
                                           input logic [3:0] sel);
    logic [31:0] res;
    res = old_v;
    for (int b = 0; b < 4; b++) begin
      if (sel[b]) begin
        res[b*8 +: 8] = new_v[b*8 +: 8];
      end
    end
    return res;
  endfunction : wb_merge

  // Squared per-unit current, 0x0100 = 1.0, saturated to 16 bits
  function automatic logic [15:0] sq_pu(input logic [15:0] i);
    logic [31:0] p;
    p = i * i;
    return (|p[31:24]) ? 16'hffff : p[23:8];
  endfunction : sq_pu

  // Registers
  logic [31:0]          ctrl_reg;
  logic [2:0]           group_reg;
  logic [4:0]           irq_stat_reg;
  logic [4:0]           irq_mask_reg;
  logic [2:0]           set_index_reg;
  logic [31:0]          set_levels_reg;
  logic                 ack_reg;
  logic [31:0]          rdata_reg;
  logic [CNT_WIDTH-1:0] cnt_reg [NUM_OUTS];
  logic [31:0]          ms_div_reg;
  logic [31:0]          ms_count_reg;
  // Pipeline registers
  logic                 s1_valid_reg;
  logic [15:0]          s1_imax_reg;
  logic [15:0]          s1_heat_reg;
  logic                 s1_running_reg;
  logic                 s2_valid_reg;
  logic [15:0]          theta_reg;
  logic [3:0]           s3_cmp_reg;
  logic [4:0]           s4_chk_reg;
  logic [4:0]           out_reg;
  logic [4:0]           pend_reg;

  // Bus decode
  wire                  bus_req   = I_WB_CYC & I_WB_STB & ~ack_reg;
  wire                  bus_wr    = bus_req & I_WB_WE;
  wire                  bus_rd    = bus_req & ~I_WB_WE;
  wire                  wr_ctrl   = bus_wr & (I_WB_ADR == REG_CTRL);
  wire                  wr_group  = bus_wr & (I_WB_ADR == REG_GROUP);
  wire                  wr_mask   = bus_wr & (I_WB_ADR == REG_IRQ_MASK);
  wire                  wr_clr    = bus_wr & (I_WB_ADR == REG_CNT_CLR);
  wire                  wr_index  = bus_wr & (I_WB_ADR == REG_SET_INDEX);
  wire                  wr_levels = bus_wr & (I_WB_ADR == REG_SET_LEVELS);
  wire                  wr_timing = bus_wr & (I_WB_ADR == REG_SET_TIMING) & (&I_WB_SEL[2:0]);
  wire                  rd_irq    = bus_rd & (I_WB_ADR == REG_IRQ_STAT);
  wire [4:0]            cnt_clear = wr_clr ? (I_WB_DAT[4:0] & {5{I_WB_SEL[0]}}) : 5'h00;
  wire [2:0]            cnt_sel   = I_WB_ADR[4:2];
  wire                  cnt_hit   = (I_WB_ADR[7:5] == REG_CNT_BASE[7:5]) & (cnt_sel < 3'h5)
                                    & (I_WB_ADR[1:0] == 2'h0);

  // Control fields
  wire                  stage_enable_setting = ctrl_reg[CTRL_EN_BIT];                     // R12
  wire                  force_enable         = ctrl_reg[CTRL_FEN_BIT];
  wire tmos_force_type  stage_force_setting  = tmos_force_type'(ctrl_reg[CTRL_FCODE_LSB +: 3]);

  // Active parameter set read from the set memory
  tmos_set_type         cfg;
  wire tmos_set_type    set_wr_data = {set_levels_reg, I_WB_DAT[19:0]};

  tmos_set_mem #(
    .DEPTH (NUM_SETS),
    .WIDTH ($bits(tmos_set_type))
  ) u_set_mem (
    .i_clk     (I_SYS_CLK),
    .i_wr_en   (wr_timing),
    .i_wr_addr (set_index_reg),
    .i_wr_data (set_wr_data),
    .i_rd_addr (group_reg),                                                               // R1
    .o_rd_data (cfg)
  );

  // Control, group and set-staging registers
  always_ff @(posedge I_SYS_CLK or posedge I_SYS_RST) begin
    if (I_SYS_RST) begin
      ctrl_reg       <= CTRL_RESET;                                                       // R12
      group_reg      <= GROUP_RESET;
      irq_mask_reg   <= 5'h00;
      set_index_reg  <= 3'h0;
      set_levels_reg <= 32'h0000_0000;
    end else begin
      if (wr_ctrl)   ctrl_reg       <= wb_merge(ctrl_reg, I_WB_DAT, I_WB_SEL);
      if (wr_group && I_WB_SEL[0]) group_reg <= I_WB_DAT[2:0];                            // R2
      if (wr_mask && I_WB_SEL[0])  irq_mask_reg <= I_WB_DAT[4:0];
      if (wr_index && I_WB_SEL[0]) set_index_reg <= I_WB_DAT[2:0];
      if (wr_levels) set_levels_reg <= wb_merge(set_levels_reg, I_WB_DAT, I_WB_SEL);
    end
  end

  // Read mux
  logic [31:0] rd_mux;
  assign rd_mux = (I_WB_ADR == REG_CTRL)       ? ctrl_reg :
                  (I_WB_ADR == REG_GROUP)      ? {29'h0, group_reg} :
                  (I_WB_ADR == REG_STATE)      ? {27'h0, out_reg} :
                  (I_WB_ADR == REG_THETA)      ? {16'h0, theta_reg} :
                  (I_WB_ADR == REG_IRQ_STAT)   ? {27'h0, irq_stat_reg} :
                  (I_WB_ADR == REG_IRQ_MASK)   ? {27'h0, irq_mask_reg} :
                  (I_WB_ADR == REG_SET_INDEX)  ? {29'h0, set_index_reg} :
                  (I_WB_ADR == REG_SET_LEVELS) ? set_levels_reg :
                  cnt_hit ? {{(32-CNT_WIDTH){1'b0}}, cnt_reg[cnt_sel]} : 32'h0000_0000;

  // Single-cycle answer, unmapped addresses read zero
  always_ff @(posedge I_SYS_CLK or posedge I_SYS_RST) begin
    if (I_SYS_RST) begin
      ack_reg   <= 1'b0;
      rdata_reg <= 32'h0000_0000;
    end else begin
      ack_reg   <= bus_req;
      rdata_reg <= bus_rd ? rd_mux : 32'h0000_0000;
    end
  end
  assign O_WB_ACK = ack_reg;
  assign O_WB_DAT = rdata_reg;

  // Stage 1: magnitude processing of the 5 ms sample
  wire [15:0] ia = I_MEAS.phase_a_rms_current;                                            // R6
  wire [15:0] ib = I_MEAS.phase_b_rms_current;
  wire [15:0] ic = I_MEAS.phase_c_rms_current;
  wire [15:0] iab_max = (ia > ib) ? ia : ib;
  wire [15:0] imax    = (iab_max > ic) ? iab_max : ic;
  wire [17:0] heat_sum = {2'b00, sq_pu(imax)} + {2'b00, sq_pu(I_MEAS.neg_seq_current)}
                         + {2'b00, I_MEAS.ambient_temp >> AMB_SHIFT};                     // R9
  always_ff @(posedge I_SYS_CLK or posedge I_SYS_RST) begin
    if (I_SYS_RST) begin
      s1_valid_reg   <= 1'b0;
      s1_imax_reg    <= 16'h0000;
      s1_heat_reg    <= 16'h0000;
      s1_running_reg <= 1'b0;
    end else begin
      s1_valid_reg <= I_MEAS_VALID & stage_enable_setting;                                // R7
      if (I_MEAS_VALID) begin
        s1_imax_reg    <= imax;                                                           // R3
        s1_heat_reg    <= (|heat_sum[17:16]) ? 16'hffff : heat_sum[15:0];
        s1_running_reg <= |I_MEAS.pos_seq_current;                                        // R8
      end
    end
  end

  // Stage 2: thermal replica with automatic time-constant choice
  wire        cooling   = ~s1_running_reg | (s1_heat_reg < theta_reg);
  wire        stalled   = s1_imax_reg[15:8] >= cfg.stall_lvl;
  wire [3:0]  tau_shift = cooling ? cfg.cool_shift :
                          stalled ? cfg.short_shift : cfg.heat_shift;                     // R10
  wire signed [16:0] diff  = $signed({1'b0, s1_heat_reg}) - $signed({1'b0, theta_reg});
  wire signed [16:0] delta = diff >>> tau_shift;
  wire signed [16:0] theta_sum = $signed({1'b0, theta_reg}) + delta;
  always_ff @(posedge I_SYS_CLK or posedge I_SYS_RST) begin
    if (I_SYS_RST) begin
      s2_valid_reg <= 1'b0;
      theta_reg    <= 16'h0000;
    end else begin
      s2_valid_reg <= s1_valid_reg;
      if (s1_valid_reg) theta_reg <= theta_sum[15:0];                                     // R3
    end
  end

  // Stages 3 to 5: comparator, block check, output processing with forcing
  wire [7:0] theta_lvl = theta_reg[11:4];
  wire [3:0] cmp = {theta_lvl >= cfg.inhibit_lvl, theta_lvl >= cfg.alarm2_lvl,
                    theta_lvl >= cfg.alarm1_lvl, theta_lvl >= cfg.trip_lvl};
  wire [4:0] chk = I_BLOCK ? 5'b10000 : {1'b0, s3_cmp_reg};                               // R14
  logic [4:0] out_next;
  always_comb begin
    out_next = s4_chk_reg;
    if (force_enable) begin
      unique case (stage_force_setting)                                                   // R13
        FORCE_NORMAL:  out_next = s4_chk_reg;
        FORCE_BLOCKED: out_next = 5'b1 << OUT_BLOCKED;
        FORCE_ALARM1:  out_next = 5'b1 << OUT_ALARM1;
        FORCE_ALARM2:  out_next = 5'b1 << OUT_ALARM2;
        FORCE_INHIBIT: out_next = 5'b1 << OUT_INHIBIT;
        FORCE_TRIP:    out_next = 5'b1 << OUT_TRIP;
        default:       out_next = s4_chk_reg;
      endcase
    end
    if (!stage_enable_setting) out_next = 5'h00;                                          // R12
  end
  always_ff @(posedge I_SYS_CLK or posedge I_SYS_RST) begin
    if (I_SYS_RST) begin
      s3_cmp_reg <= 4'h0;
      s4_chk_reg <= 5'h00;
      out_reg    <= 5'h00;
    end else begin
      s3_cmp_reg <= cmp;                                                                  // R3
      s4_chk_reg <= chk;
      out_reg    <= out_next;
    end
  end
  assign O_STATE = out_reg;

  // Millisecond time base for event stamps
  always_ff @(posedge I_SYS_CLK or posedge I_SYS_RST) begin
    if (I_SYS_RST) begin
      ms_div_reg   <= 32'h0000_0000;
      ms_count_reg <= 32'h0000_0000;
    end else if (ms_div_reg == 32'(MS_CYCLES - 1)) begin
      ms_div_reg   <= 32'h0000_0000;
      ms_count_reg <= ms_count_reg + 32'h0000_0001;                                       // R4
    end else begin
      ms_div_reg   <= ms_div_reg + 32'h0000_0001;
    end
  end

  // Event emission: one pending edge per cycle, lowest id first
  wire [4:0] edges    = out_next ^ out_reg;
  wire [4:0] pick     = pend_reg & (~pend_reg + 5'h01);
  wire [2:0] pick_id  = pick[0] ? 3'd0 : pick[1] ? 3'd1 : pick[2] ? 3'd2 :
                        pick[3] ? 3'd3 : 3'd4;
  always_ff @(posedge I_SYS_CLK or posedge I_SYS_RST) begin
    if (I_SYS_RST) begin
      pend_reg    <= 5'h00;
      O_EVT_VALID <= 1'b0;
      O_EVT       <= '0;
    end else begin
      pend_reg    <= (pend_reg & ~pick) | edges;                                          // R4
      O_EVT_VALID <= |pend_reg;
      if (|pend_reg) O_EVT <= '{signal_id: pick_id, is_on: out_reg[pick_id],
                                stamp_ms: ms_count_reg};
    end
  end

  // Rising edges of outputs feed counters and sticky interrupt bits
  wire [4:0] rises = out_next & ~out_reg;
  always_ff @(posedge I_SYS_CLK or posedge I_SYS_RST) begin
    if (I_SYS_RST) begin
      irq_stat_reg <= 5'h00;
      for (int k = 0; k < NUM_OUTS; k++) cnt_reg[k] <= '0;
    end else begin
      irq_stat_reg <= (rd_irq ? 5'h00 : irq_stat_reg) | rises;
      for (int k = 0; k < NUM_OUTS; k++) begin
        if (cnt_clear[k]) cnt_reg[k] <= '0;                                               // R5
        else if (rises[k] && !(&cnt_reg[k])) cnt_reg[k] <= cnt_reg[k] + 1'b1;             // R15
      end
    end
  end
  assign O_IRQ = |(irq_stat_reg & irq_mask_reg);

  // Assertions
  sequence seq_sample_in;
    I_MEAS_VALID && stage_enable_setting;
  endsequence
  sequence seq_replica_out;
    s1_valid_reg ##1 s2_valid_reg;
  endsequence

  a_ack_single_pulse: assert property (@(posedge I_SYS_CLK) disable iff (I_SYS_RST) // R2
    O_WB_ACK |=> !O_WB_ACK) else $error("ack stood two cycles");
  a_replica_order: assert property (@(posedge I_SYS_CLK) disable iff (I_SYS_RST) // R3
    seq_sample_in |=> seq_replica_out) else $error("sample did not walk the pipeline");
  a_sample_consumed: assert property (@(posedge I_SYS_CLK) disable iff (I_SYS_RST) // R7
    s1_valid_reg |=> theta_reg == $past(theta_sum[15:0])) else $error("replica missed sample");
  a_disabled_quiet: assert property (@(posedge I_SYS_CLK) disable iff (I_SYS_RST) // R12
    !stage_enable_setting |=> O_STATE == 5'h00) else $error("outputs active while disabled");
  a_block_masks: assert property (@(posedge I_SYS_CLK) disable iff (I_SYS_RST) // R14
    I_BLOCK && !force_enable && stage_enable_setting ##1 !force_enable && stage_enable_setting
    |=> O_STATE == 5'b10000) else $error("block did not hold outputs");
  a_force_trip: assert property (@(posedge I_SYS_CLK) disable iff (I_SYS_RST) // R13
    stage_enable_setting && force_enable && stage_force_setting == FORCE_TRIP
    |=> O_STATE == 5'b00001) else $error("forced trip not shown");
  a_edge_event: assert property (@(posedge I_SYS_CLK) disable iff (I_SYS_RST) // R4
    |edges |-> ##[1:6] O_EVT_VALID) else $error("output edge gave no event");
  a_count_clear: assert property (@(posedge I_SYS_CLK) disable iff (I_SYS_RST) // R5
    cnt_clear[OUT_TRIP] |=> cnt_reg[OUT_TRIP] == '0) else $error("trip counter not cleared");
  a_count_saturate: assert property (@(posedge I_SYS_CLK) disable iff (I_SYS_RST) // R15
    &cnt_reg[OUT_ALARM1] && !cnt_clear[OUT_ALARM1] |=> &cnt_reg[OUT_ALARM1])
    else $error("alarm1 counter wrapped");
  a_trip_counted: assert property (@(posedge I_SYS_CLK) disable iff (I_SYS_RST) // R5
    rises[OUT_TRIP] && !cnt_clear[OUT_TRIP] && !(&cnt_reg[OUT_TRIP])
    |=> cnt_reg[OUT_TRIP] == $past(cnt_reg[OUT_TRIP]) + 1'b1) else $error("trip not counted");
  a_group_applied: assert property (@(posedge I_SYS_CLK) disable iff (I_SYS_RST) // R1
    wr_group && I_WB_SEL[0] |=> group_reg == $past(I_WB_DAT[2:0])) else $error("group ignored");
endmodule : tmos_stage

// ---- tb/testbench.sv ----
// Self-checking bench of the thermal overload stage over Wishbone and the measurement port
module testbench;
  timeunit 1ns;
  timeprecision 100ps;
  import tmos_pkg::*;
  logic           clk;
  logic           rst;
  logic           cyc;
  logic           stb;
  logic           we;
  logic [7:0]     adr;
  logic [31:0]    wdat;
  logic [3:0]     sel;
  logic [31:0]    rdat;
  logic           ack;
  logic           mvalid;
  tmos_meas_type  meas;
  tmos_meas_type  sample;
  logic           blk;
  logic [4:0]     state;
  logic           evt_valid;
  tmos_event_type evt;
  logic           irq;
  tmos_event_type evq[$];
  logic [31:0]    rdata;
  logic [31:0]    stamp_a;
  int             failures;
  int             checked;

  tmos_stage #(.MS_CYCLES(20)) tmos_stage_i (
    .I_SYS_CLK(clk), .I_SYS_RST(rst), .I_WB_CYC(cyc), .I_WB_STB(stb), .I_WB_WE(we),
    .I_WB_ADR(adr), .I_WB_DAT(wdat), .I_WB_SEL(sel), .O_WB_DAT(rdat), .O_WB_ACK(ack),
    .I_MEAS_VALID(mvalid), .I_MEAS(meas), .I_BLOCK(blk), .O_STATE(state),
    .O_EVT_VALID(evt_valid), .O_EVT(evt), .O_IRQ(irq));

  tmos_meas_src #(.PERIOD(40)) tmos_meas_src_i (
    .i_clk(clk), .i_rst(rst), .i_sample(sample), .o_valid(mvalid), .o_meas(meas));

  task automatic tally_and_finish();
    if (failures == 0 && checked > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : tally_and_finish

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      failures++;
      $display("unexpected at %0t ns: got %h expected %h", $time, got, exp);
    end
  endtask : check

  // One classic cycle: hold everything until ack is sampled, then release
  task automatic wb_cycle(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    cyc  <= 1'b1;
    stb  <= 1'b1;
    we   <= w;
    adr  <= a;
    wdat <= d;
    sel  <= 4'hf;
    do begin
      @(posedge clk);
    end while (ack !== 1'b1);
    rdata = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    we  <= 1'b0;
  endtask : wb_cycle

  task automatic wb_read_check(input logic [7:0] a, input logic [31:0] exp);
    wb_cycle(1'b0, a, 32'h0);
    check(rdata, exp);
  endtask : wb_read_check

  // Bounded wait for the output levels, then let pending events drain
  task automatic wait_state(input logic [4:0] exp);
    int n;
    n = 0;
    while (state !== exp && n < 300) begin
      @(posedge clk);
      n++;
    end
    check({27'h0, state}, {27'h0, exp});
    repeat (8) @(posedge clk);
  endtask : wait_state

  // Expected event as {signal id, on flag}
  task automatic check_evt(input logic [3:0] exp);
    tmos_event_type e;
    e = 'x;
    if (evq.size() > 0) e = evq.pop_front();
    stamp_a = e.stamp_ms;
    check({28'h0, e.signal_id, e.is_on}, {28'h0, exp});
  endtask : check_evt

  // Clock source and event capture
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  always @(posedge clk) if (evt_valid === 1'b1) evq.push_back(evt);

  initial begin : watchdog
    #100000;
    failures++;
    tally_and_finish();
  end

  initial begin
    logic [31:0] t0;
    logic [4:0]  fexp [6];
    fexp = '{5'h00, 5'h10, 5'h02, 5'h04, 5'h08, 5'h01};
    {rst, cyc, stb, we, blk} = 5'b10000;
    adr = 8'h0;
    wdat = 32'h0;
    sel = 4'h0;
    sample = {16'h0100, 32'h0, 16'h0100, 16'h0, 16'h0010};
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    check({27'h0, state}, 32'h0);
    wb_read_check(REG_CTRL, CTRL_RESET);
    wb_read_check(REG_GROUP, 32'h0);
    wb_read_check(8'h3c, 32'h0);
    for (int k = 0; k < 8; k++) begin
      wb_write_set(k);
    end
    wb_read_check(REG_THETA, 32'h0);
    wb_cycle(1'b1, REG_CTRL, 32'h1);
    wait_state(5'h00);
    wb_cycle(1'b1, REG_GROUP, 32'h1);
    wait_state(5'h0f);
    for (int k = 0; k < 4; k++) check_evt({k[2:0], 1'b1});
    t0 = stamp_a;
    for (int k = 0; k < 5; k++) wb_read_check(REG_CNT_BASE + 8'(4 * k), (k < 4));
    check({31'h0, irq}, 32'h0);
    wb_cycle(1'b1, REG_IRQ_MASK, 32'h1f);
    @(posedge clk);
    check({31'h0, irq}, 32'h1);
    wb_read_check(REG_IRQ_STAT, 32'h0f);
    @(posedge clk);
    check({31'h0, irq}, 32'h0);
    blk <= 1'b1;
    wait_state(5'h10);
    for (int k = 0; k < 4; k++) check_evt({k[2:0], 1'b0});
    check_evt(4'h9);
    check({31'h0, stamp_a > t0}, 32'h1);
    wb_read_check(REG_CNT_BASE + 8'h10, 32'h1);
    wb_read_check(REG_IRQ_STAT, 32'h10);
    wb_cycle(1'b0, REG_THETA, 32'h0);
    check({31'h0, rdata != 32'h0}, 32'h1);
    blk <= 1'b0;
    wait_state(5'h0f);
    wb_cycle(1'b1, REG_CNT_CLR, 32'h1f);
    for (int k = 0; k < 5; k++) wb_read_check(REG_CNT_BASE + 8'(4 * k), 32'h0);
    for (int k = 7; k >= 0; k--) begin
      wb_cycle(1'b1, REG_GROUP, 32'(k));
      wait_state(k[0] ? 5'h0f : 5'h00);
    end
    for (int k = 0; k < 6; k++) begin
      wb_cycle(1'b1, REG_CTRL, 32'h3 | 32'(k << 4));
      wait_state(fexp[k]);
    end
    wb_cycle(1'b1, REG_CTRL, 32'h1);
    wb_cycle(1'b1, REG_GROUP, 32'h1);
    wait_state(5'h0f);
    wb_cycle(1'b1, REG_CTRL, 32'h0);
    wait_state(5'h00);
    tally_and_finish();
  end

  // Odd sets trip every level, even sets never do at this load; cooling twice as slow
  task automatic wb_write_set(input int k);
    wb_cycle(1'b1, REG_SET_INDEX, 32'(k));
    wb_cycle(1'b1, REG_SET_LEVELS, (k % 2) ? 32'h0 : 32'hffff_ffff);
    wb_cycle(1'b1, REG_SET_TIMING, 32'h000f_f454);
  endtask : wb_write_set
endmodule : testbench

// ---- tb/tmos_meas_src.sv ----
// Measurement source model: periodic RMS, sequence and ambient samples
module tmos_meas_src
  import tmos_pkg::*;
#(
  parameter int unsigned PERIOD = 40
) (
  input  wire logic          i_clk,
  input  wire logic          i_rst,
  input  wire tmos_meas_type i_sample,
  output logic               o_valid,
  output tmos_meas_type      o_meas
);
  timeunit 1ns;
  timeprecision 100ps;
  int unsigned count_reg;
  logic        fire;

  // Strobe falls on the last count of each update period
  assign fire = (count_reg == PERIOD - 1);

  // One strobe per period carries a fresh sample; between strobes the bus toggles
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      count_reg <= 0;
      o_valid   <= 1'b0;
      o_meas    <= '0;
    end else begin
      count_reg <= fire ? 0 : count_reg + 1;
      o_valid   <= fire;
      o_meas    <= fire ? i_sample : ~o_meas;
    end
  end
endmodule : tmos_meas_src
